// file: ioe_pkg.sv
/*
 * holds the shared constants, modes and carrier structs of the i/o element
 * and of the row i/o block.
 * assumes nothing of its surroundings; pulled in by scoped names only.
 */
package ioe_pkg;
   // ***********************************************************************
   // block sizes
   // ***********************************************************************
   localparam int unsigned ROW_ELEMS = 4; // elements in one row i/o block
   localparam int unsigned COL_ELEMS = 6; // elements in one column block
   localparam int unsigned SHARED_LINES = 4; // per kind of shared control

   // ***********************************************************************
   // transfer modes
   // ***********************************************************************
   typedef enum logic [1:0]
   {
      IOE_MODE_SDR = 2'b00,
      IOE_MODE_DDR = 2'b01
   } ioe_mode_t;

   // routing target of an i/o block
   typedef enum logic [1:0]
   {
      IOE_ROUTE_ROW = 2'b00,
      IOE_ROUTE_COL = 2'b01,
      IOE_ROUTE_DIRECT = 2'b10
   } ioe_route_t;

   // per element configuration
   typedef struct packed
   {
      ioe_mode_t mode;
      logic in_clk_sel;  // 0: per element input enable, 1: shared enable
      logic out_clk_sel;
      logic oe_neg_sel;  // use falling edge oe register
      logic clr_sel;     // 0: per element clear, 1: shared clear
      logic power_up_high;
   } ioe_cfg_t;

   // per element control from the fabric
   typedef struct packed
   {
      logic dout_a;
      logic dout_b;
      logic oe;
      logic ce_in;
      logic ce_out;
      logic clr;
      logic sclr;
   } ioe_ctrl_t;

   // captured input pair
   typedef struct packed
   {
      logic rise_bit;
      logic fall_bit;
   } ioe_din_t;

   localparam logic RST_LOW = 1'b0;
endpackage

// file: ioe_element.sv
/*
 * holds one i/o element: two input registers and a latch, two output
 * registers, two output enable registers and the pin driver signals.
 * assumes clock and clear have been selected by the enclosing block.
 */
`timescale 1ns/100ps
module ioe_element
(
   // clocks and clear
   input wire logic clk_i,
   input wire logic aclr_i,
   // configuration and control
   input wire ioe_pkg::ioe_cfg_t cfg_i,
   input wire ioe_pkg::ioe_ctrl_t ctrl_i,
   // pin
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   // fabric data
   output ioe_pkg::ioe_din_t din_o
);
   logic in_rise_reg, in_fall_reg, in_lat;
   logic out_a_reg, out_b_reg, oe_reg, oe_neg_reg;
   logic pu;
   assign pu = cfg_i.power_up_high;

   // input registers capture on alternate edges
   always_ff @(posedge clk_i or posedge aclr_i)
      if (aclr_i)
         in_rise_reg <= 1'b0;
      else if (ctrl_i.sclr)
         in_rise_reg <= pu;
      else if (ctrl_i.ce_in)
         in_rise_reg <= pin_i;

   always_ff @(negedge clk_i or posedge aclr_i)
      if (aclr_i)
         in_fall_reg <= 1'b0;
      else if (ctrl_i.sclr)
         in_fall_reg <= pu;
      else if (ctrl_i.ce_in)
         in_fall_reg <= pin_i;

   // latch passes the rising edge bit while the clock is high and holds it while low
   always_latch
      if (clk_i)
         in_lat <= in_rise_reg;

   // output and oe registers share clock and enable
   always_ff @(posedge clk_i or posedge aclr_i)
      if (aclr_i)
      begin
         out_a_reg <= 1'b0;
         out_b_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else if (ctrl_i.sclr)
      begin
         out_a_reg <= pu;
         out_b_reg <= pu;
         oe_reg <= pu;
      end
      else if (ctrl_i.ce_out)
      begin
         out_a_reg <= ctrl_i.dout_a;
         out_b_reg <= ctrl_i.dout_b;
         oe_reg <= ctrl_i.oe;
      end

   // falling edge oe register for ddr sdram
   always_ff @(negedge clk_i or posedge aclr_i)
      if (aclr_i)
         oe_neg_reg <= 1'b0;
      else if (ctrl_i.sclr)
         oe_neg_reg <= pu;
      else if (ctrl_i.ce_out)
         oe_neg_reg <= oe_reg;

   // clock-selected mux and pin enable
   assign pin_o = (cfg_i.mode == ioe_pkg::IOE_MODE_DDR && !clk_i) ? out_b_reg : out_a_reg;
   assign pin_oe_o = cfg_i.oe_neg_sel ? oe_neg_reg : oe_reg;
   assign din_o.rise_bit = (cfg_i.mode == ioe_pkg::IOE_MODE_DDR) ? in_lat : in_rise_reg;
   assign din_o.fall_bit = in_fall_reg;

   a_oe_follows: assert property (@(posedge clk_i) disable iff (aclr_i)
      (ctrl_i.ce_out && !ctrl_i.sclr) |=> (oe_reg == $past(ctrl_i.oe)))
      else $error("oe register missed load");
   a_hold_ce: assert property (@(posedge clk_i) disable iff (aclr_i)
      (!ctrl_i.ce_out && !ctrl_i.sclr) |=> $stable(out_a_reg))
      else $error("output register changed while disabled");
   // second output bit holds as well while its enable is low
   a_hold_b: assert property (@(posedge clk_i) disable iff (aclr_i)
      (!ctrl_i.ce_out && !ctrl_i.sclr) |=> $stable(out_b_reg))
      else $error("second output register changed while disabled");
   // input capture holds while its own enable is low
   a_hold_in: assert property (@(posedge clk_i) disable iff (aclr_i)
      (!ctrl_i.ce_in && !ctrl_i.sclr) |=> $stable(in_rise_reg))
      else $error("input register changed while disabled");
   // synchronous clear loads the power-up value
   a_sclr_load: assert property (@(posedge clk_i) disable iff (aclr_i)
      ctrl_i.sclr |=> (out_a_reg == $past(pu) && oe_reg == $past(pu)))
      else $error("synchronous clear missed power-up value");
   // falling edge oe register follows the rising edge one half a cycle later
   a_neg_oe: assert property (@(negedge clk_i) disable iff (aclr_i)
      (ctrl_i.ce_out && !ctrl_i.sclr) |=> (oe_neg_reg == $past(oe_reg)))
      else $error("falling edge oe register missed load");
endmodule

// file: ioe_row_block.sv
/*
 * holds a row i/o block of four i/o elements with shared and per element
 * control lines from the fabric.
 * assumes the fabric supplies fourteen shared and twenty-eight per element lines.
 */
`timescale 1ns/100ps
// What this block does
// - six registers plus one latch per element
// - full bidirectional sdr or ddr transfer
// - ddr input uses both registers and latch
// - ddr output uses both output registers
// - output enable switches from a register
// - one oe register clocked on falling edge
// - row block four, column block six elements
// - row block routes row in reset, then direct
// - ddr output loads rising, clock muxes bits
// - ddr input alternate edges, latch aligns bits
// - output and oe share clock and enable
// - one clear source clears to 0; power-up sets sclr value
module ioe_row_block
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // shared control lines
   input wire logic [3:0] bus_oe_i,
   input wire logic [3:0] bus_ce_i,
   input wire logic [3:0] bus_clr_i,
   input wire logic [1:0] bus_sel_i,
   // per element lines
   input wire logic [3:0] dout_a_i,
   input wire logic [3:0] dout_b_i,
   input wire logic [3:0] elem_oe_i,
   input wire logic [3:0] ce_in_i,
   input wire logic [3:0] ce_out_i,
   input wire logic [3:0] elem_clr_i,
   input wire logic [3:0] sclr_i,
   input wire ioe_pkg::ioe_cfg_t [3:0] cfg_i,
   // pins
   input wire logic [3:0] pin_i,
   output logic [3:0] pin_o,
   output logic [3:0] pin_oe_o,
   // fabric routing
   output ioe_pkg::ioe_din_t [3:0] din_o,
   output ioe_pkg::ioe_route_t route_o
);
   logic rst_s1, rst_s2;
   // reset release through two flops
   always_ff @(posedge core_clk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         rst_s1 <= ioe_pkg::RST_LOW;
         rst_s2 <= ioe_pkg::RST_LOW;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end

   // row block may drive direct links
   always_ff @(posedge core_clk_i or negedge rst_s2)
      if (!rst_s2)
         route_o <= ioe_pkg::IOE_ROUTE_ROW;
      else
         route_o <= ioe_pkg::IOE_ROUTE_DIRECT;

   // four elements per row block
   genvar g;
   generate
      for (g = 0; g < ioe_pkg::ROW_ELEMS; g++)
      begin : gen_el
         ioe_pkg::ioe_ctrl_t ctrl;
         logic aclr;
         // clear select shared by all registers of the element
         assign aclr = !rst_s2 | (cfg_i[g].clr_sel ? bus_clr_i[bus_sel_i] : elem_clr_i[g]);
         assign ctrl.dout_a = dout_a_i[g];
         assign ctrl.dout_b = dout_b_i[g];
         assign ctrl.oe = cfg_i[g].out_clk_sel ? bus_oe_i[bus_sel_i] : elem_oe_i[g];
         assign ctrl.ce_in = cfg_i[g].in_clk_sel ? bus_ce_i[bus_sel_i] : ce_in_i[g];
         assign ctrl.ce_out = cfg_i[g].out_clk_sel ? bus_ce_i[bus_sel_i] : ce_out_i[g];
         assign ctrl.clr = aclr;
         assign ctrl.sclr = sclr_i[g];
         ioe_element u_el
         (
            .clk_i(core_clk_i),
            .aclr_i(aclr),
            .cfg_i(cfg_i[g]),
            .ctrl_i(ctrl),
            .pin_i(pin_i[g]),
            .pin_o(pin_o[g]),
            .pin_oe_o(pin_oe_o[g]),
            .din_o(din_o[g])
         );
      end
   endgenerate

   // ***********************************************************************
   // checks on reset release and routing
   // ***********************************************************************
   // released reset walks through the second flop one edge later
   a_rst_chain: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      rst_s1 |=> rst_s2)
      else $error("reset release did not reach second flop");
   // once out of reset the row block offers direct links
   a_route_direct: assert property (@(posedge core_clk_i) disable iff (!rst_s2)
      rst_s2 |=> (route_o == ioe_pkg::IOE_ROUTE_DIRECT))
      else $error("row block not on direct routing");
endmodule

// file: ioe_pin_model.sv
/*
 * outside device on the four pins: drives ddr data whenever the row
 * block releases a pin, and resolves the wire level for the block.
 * assumes the same core clock as the row block.
 */
`timescale 1ns/100ps
module ioe_pin_model
(
   // clock and pattern phase
   input wire logic clk_i,
   input wire logic inv_i,
   // row block pin side
   input wire logic [3:0] pin_o_i,
   input wire logic [3:0] pin_oe_i,
   output logic [3:0] pin_lvl_o
);
   logic [3:0] ext_lvl;
   // ***********************************************************************
   // outside ddr driver
   // ***********************************************************************
   // new bit each half period, 1 ns after the edge, so hold time is met
   always @(clk_i)
   begin
      ext_lvl <= #1 {4{clk_i ^ inv_i}};
   end
   // the block wins where it drives, the outside device elsewhere
   assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_lvl);
endmodule

// file: ioe_row_block_tb.sv
/*
 * self-checking bench of the row i/o block: reset, then table of output
 * transfers, then clears and ddr capture by hand.
 * assumes the pin model resolves the pins.
 */
`timescale 1ns/100ps
module ioe_row_block_tb;
   typedef struct packed
   {
      ioe_pkg::ioe_mode_t mode;
      logic neg;
      logic [3:0] ce, oe, a, b, hi, lo, oe_hi, oe_lo;
   } ioe_row_t;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] dout_a = '0, dout_b = '0, oe = '0, ce_in = '0, ce_out = '0, clr = '0, sclr = '0;
   logic [3:0] pin_lvl, pin_o, pin_oe;
   logic inv = 1'b0;
   ioe_pkg::ioe_cfg_t [3:0] cfg = '0;
   ioe_pkg::ioe_din_t [3:0] din;
   ioe_pkg::ioe_route_t route;
   int num_errors = 0;
   int num_checks = 0;
   int i;
   ioe_row_t rows [6];
   // clock at 250 MHz
   always #2 core_clk_i = ~core_clk_i;
   ioe_row_block dut
   (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .bus_oe_i(4'h0), .bus_ce_i(4'hf), .bus_clr_i(4'h0), .bus_sel_i(2'h0),
      .dout_a_i(dout_a), .dout_b_i(dout_b), .elem_oe_i(oe), .ce_in_i(ce_in),
      .ce_out_i(ce_out), .elem_clr_i(clr), .sclr_i(sclr), .cfg_i(cfg),
      .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe), .din_o(din), .route_o(route)
   );
   ioe_pin_model model
   (
      .clk_i(core_clk_i), .inv_i(inv), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_lvl_o(pin_lvl)
   );
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task results;
      if (num_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task set_cfg(input ioe_pkg::ioe_mode_t m, input logic neg, input logic pu);
      cfg <= {4{m, 1'b0, 1'b0, neg, 1'b0, pu}};
   endtask
   // ***********************************************************************
   // main sequence
   // ***********************************************************************
   initial
   begin
      rows = '{'{ioe_pkg::IOE_MODE_SDR, 1'b0, 4'hf, 4'hf, 4'ha, 4'h5, 4'ha, 4'ha, 4'hf, 4'hf},
               '{ioe_pkg::IOE_MODE_DDR, 1'b0, 4'hf, 4'hf, 4'h3, 4'hc, 4'h3, 4'hc, 4'hf, 4'hf},
               '{ioe_pkg::IOE_MODE_DDR, 1'b0, 4'h0, 4'h0, 4'h0, 4'hf, 4'h3, 4'hc, 4'hf, 4'hf},
               '{ioe_pkg::IOE_MODE_DDR, 1'b0, 4'h5, 4'h0, 4'h0, 4'hf, 4'h2, 4'hd, 4'ha, 4'ha},
               '{ioe_pkg::IOE_MODE_SDR, 1'b0, 4'hf, 4'h0, 4'h6, 4'h9, 4'h6, 4'h6, 4'h0, 4'h0},
               '{ioe_pkg::IOE_MODE_DDR, 1'b1, 4'hf, 4'hf, 4'hf, 4'h0, 4'hf, 4'h0, 4'h0, 4'hf}};
      @(posedge core_clk_i);
      #1;
      chk("oe in reset", pin_oe, 8'h0);
      chk("route in reset", route, ioe_pkg::IOE_ROUTE_ROW);
      repeat (3) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      for (i = 0; i < 8 && route !== ioe_pkg::IOE_ROUTE_DIRECT; i++) @(posedge core_clk_i);
      chk("route", route, ioe_pkg::IOE_ROUTE_DIRECT);
      if (i == 8) results();
      repeat (3) @(posedge core_clk_i);
      // table of output transfers, checked in both clock phases
      foreach (rows[k])
      begin
         @(posedge core_clk_i);
         set_cfg(rows[k].mode, rows[k].neg, 1'b0);
         {ce_out, oe, dout_a, dout_b} <= {rows[k].ce, rows[k].oe, rows[k].a, rows[k].b};
         @(posedge core_clk_i);
         #1;
         chk("pin high", pin_o, rows[k].hi);
         chk("oe high", pin_oe, rows[k].oe_hi);
         @(negedge core_clk_i);
         #1;
         chk("pin low", pin_o, rows[k].lo);
         chk("oe low", pin_oe, rows[k].oe_lo);
      end
      // asynchronous clear, then synchronous clear to a power-up-high value
      @(posedge core_clk_i);
      clr <= 4'hf;
      #1;
      chk("oe cleared", pin_oe, 8'h0);
      chk("pin cleared", pin_o, 8'h0);
      @(posedge core_clk_i);
      clr <= 4'h0;
      set_cfg(ioe_pkg::IOE_MODE_DDR, 1'b0, 1'b1);
      {oe, dout_a, dout_b, sclr} <= 16'h000f;
      @(posedge core_clk_i);
      #1;
      chk("oe preset", pin_oe, 8'hf);
      chk("pin preset", pin_o, 8'hf);
      // ddr capture of outside data, both phases, then held
      @(posedge core_clk_i);
      sclr <= 4'h0;
      ce_in <= 4'hf;
      for (i = 0; i < 3; i++)
      begin
         repeat (4) @(posedge core_clk_i);
         @(negedge core_clk_i);
         #1;
         chk("capture", din, i == 0 ? 8'h55 : 8'haa);
         @(posedge core_clk_i);
         inv <= (i == 0);
         ce_in <= (i == 0) ? 4'hf : 4'h0;
      end
      results();
   end
endmodule
